/* hw/bcd_lookahead_adder.sv */
// 24-bit binary/bcd adder-subtracter built from six lookahead digit stages
// assumes: operands, selects and control come from logic on clk_i, no syncing
//
// Notes on behaviour
// (RQ1) six cascaded 4-bit stages with carry logic
// (RQ2) a and b operands picked from listed sources
// (RQ3) sum bit is a xor b xor carry
// (RQ4) add propagate when exactly one bit set
// (RQ5) add generate only when both bits set
// (RQ6) stage carries formed in parallel, no ripple
// (RQ7) weight-2 carry from g1 or p1 with cin
// (RQ8) weight-4 carry: g2, p2g1, p2p1cin
// (RQ9) weight-8 carry from generates through propagate chain
// (RQ10) stage carry: internal carry or all-propagate cin
// (RQ11) top selected stage carry cut, shown as level
// (RQ12) software keeps the carry itself if wanted
// (RQ13) carry flag enters lowest stage as carry
// (RQ14) length sets width, mode 00 binary 01 bcd
// (RQ15) bcd needs mode 01, length multiple of four
// (RQ16) bcd digit above nine gets plus six
// (RQ17) bcd forces carry when digit reaches ten
// (RQ18) bcd length four shows decade carry out
// (RQ19) bcd carry from adder path, not correction
// (RQ20) same unit computes a minus b minus flag
// (RQ21) subtract only when subtract select asserted
// (RQ22) bcd borrow digit corrected by minus six
`timescale 1ns/1ps
module bcd_lookahead_adder (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// operation request
	input wire logic op_valid_i,
	input wire logic subtract_i,
	input wire logic [1:0] mode_i,
	input wire logic [4:0] operand_length_field_i,
	input wire logic carry_flag_i,
	// a operand sources
	input wire logic [1:0] a_sel_i,
	input wire logic [23:0] first_operand_i,
	input wire logic [23:0] field_address_reg_i,
	input wire logic [23:0] field_length_reg_i,
	// b operand sources
	input wire logic [1:0] b_sel_i,
	input wire logic [23:0] second_operand_i,
	input wire logic [23:0] micro_literal_i,
	input wire logic [23:0] left_scratchpad_i,
	// results
	output logic [23:0] result_o,
	output logic carry_out_level_o,
	output logic [5:0] digit_carry_o,
	output logic result_valid_o
);

	logic [23:0] a_operand; // selected a data
	logic [23:0] b_operand; // selected b data
	logic [23:0] half_sum; // a xor b per bit
	logic [23:0] gen_term; // per-bit generate
	logic [23:0] prop_term; // per-bit propagate
	logic [4:0] len_eff; // length clamped into 1..24
	logic bcd_mode; // mode field selects bcd
	logic sub_mode; // subtract select from control decode
	logic [6:0] stage_carry_in; // carry into each stage, [6] unused top
	logic [24:0] all_carry; // carry into each bit, [24] beyond the top
	logic [23:0] result_next; // combined digit results
	logic carry_level_next; // carry at the selected length

	// a operand mux; unused code falls back to the first register
	always_comb begin // see (RQ2)
		case (a_sel_i)
			adder_pkg::A_SEL_FIRST: a_operand = first_operand_i;
			adder_pkg::A_SEL_ADDR: a_operand = field_address_reg_i;
			adder_pkg::A_SEL_LEN: a_operand = field_length_reg_i;
			default: a_operand = first_operand_i;
		endcase
	end

	// b operand mux; the length field is zero-extended
	always_comb begin // see (RQ2)
		case (b_sel_i)
			adder_pkg::B_SEL_SECOND: b_operand = second_operand_i;
			adder_pkg::B_SEL_LITERAL: b_operand = micro_literal_i;
			adder_pkg::B_SEL_LENFLD: b_operand = {19'h00000, operand_length_field_i};
			adder_pkg::B_SEL_SCRATCH: b_operand = left_scratchpad_i;
			default: b_operand = second_operand_i;
		endcase
	end

	// only mode 01 is bcd; other codes run binary
	assign bcd_mode = (mode_i == adder_pkg::MODE_BCD); // see (RQ14)
	// add is the resting state of the unit
	assign sub_mode = subtract_i; // see (RQ21)

	// an oversize length would index past the chain and a zero one selects nothing, so run full width
	always_comb begin // see (RQ14)
		if (operand_length_field_i == 5'h00 || operand_length_field_i > adder_pkg::LEN_FULL) begin
			len_eff = adder_pkg::LEN_FULL;
		end else begin
			len_eff = operand_length_field_i;
		end
	end

	// per-bit terms; subtract flips them into borrow generate/propagate
	genvar bit_idx;
	generate
		for (bit_idx = 0; bit_idx < adder_pkg::DATA_W; bit_idx++) begin : g_bits
			assign half_sum[bit_idx] = a_operand[bit_idx] ^ b_operand[bit_idx];
			// propagate ignores the incoming carry
			assign prop_term[bit_idx] = sub_mode ? ~half_sum[bit_idx]
				: half_sum[bit_idx]; // see (RQ4)
			// generate needs both ones when adding
			assign gen_term[bit_idx] = sub_mode ? (~a_operand[bit_idx] & b_operand[bit_idx])
				: (a_operand[bit_idx] & b_operand[bit_idx]); // see (RQ5)
		end
	endgenerate

	// carry flag is the carry (or borrow) into the lowest stage
	assign stage_carry_in[0] = carry_flag_i; // see (RQ13)
	assign all_carry[0] = carry_flag_i; // see (RQ13)

	// six digit stages chained by their lookahead carries
	genvar stg;
	generate
		for (stg = 0; stg < adder_pkg::STAGES; stg++) begin : g_stage
			logic [3:0] bit_carry; // carries into bits 1..3 and out of stage
			logic [3:0] digit; // corrected digit
			localparam int LO = stg * adder_pkg::DIGIT_W;
			lookahead_stage u_stage ( // see (RQ1)
				.half_i(half_sum[LO +: 4]),
				.gen_i(gen_term[LO +: 4]),
				.prop_i(prop_term[LO +: 4]),
				.carry_i(stage_carry_in[stg]),
				.bcd_add_i(bcd_mode & ~sub_mode),
				.bcd_sub_i(bcd_mode & sub_mode),
				.digit_o(digit),
				.bit_carry_o(bit_carry)
			);
			assign result_next[LO +: 4] = digit;
			assign all_carry[LO + 4 -: 4] = bit_carry;
			// the top selected stage keeps its carry; the next one sees zero
			assign stage_carry_in[stg + 1] = (len_eff == 5'((stg + 1) * 4)) ? 1'b0
				: bit_carry[3]; // see (RQ11)
		end
	endgenerate

	// carry level taken at the selected width; in bcd add it is the decade carry, in bcd subtract the plain borrow
	assign carry_level_next = all_carry[len_eff]; // see (RQ11) (RQ18)

	// result and carry level captured per request; the carry flag is never
	// written here, software decides whether to keep the level
	always_ff @(posedge clk_i or posedge rst_i) begin // see (RQ12)
		if (rst_i) begin
			result_o <= adder_pkg::RESULT_RST;
			carry_out_level_o <= adder_pkg::CARRY_RST;
		end else if (op_valid_i) begin
			result_o <= result_next; // see (RQ20)
			carry_out_level_o <= carry_level_next; // see (RQ11)
		end
	end

	// per-stage carries, handy for multi-word bcd work
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			digit_carry_o <= adder_pkg::DIGIT_CARRY_RST;
		end else if (op_valid_i) begin
			digit_carry_o <= {all_carry[24], all_carry[20], all_carry[16],
				all_carry[12], all_carry[8], all_carry[4]};
		end
	end

	// one-cycle pulse marking a fresh result
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= op_valid_i;
		end
	end

	// reference values read only by the checks below
	logic [24:0] ref_add; // full-width binary sum with flag
	logic [24:0] ref_sub; // full-width binary difference with flag
	logic [24:0] len_mask; // ones over the selected width
	logic [24:0] ref_len_add; // masked sum, carry sits at bit len
	logic [4:0] ref_dig_add; // low digit sum
	logic [4:0] ref_dig_sub; // low digit difference
	logic [3:0] ref_bcd_add; // expected corrected bcd sum digit
	logic [3:0] ref_bcd_sub; // expected corrected bcd difference digit
	logic digits_ok; // both low digits are legal bcd

	assign ref_add = {1'b0, a_operand} + {1'b0, b_operand} + {24'h000000, carry_flag_i};
	assign ref_sub = {1'b0, a_operand} - {1'b0, b_operand} - {24'h000000, carry_flag_i};
	assign len_mask = (25'h0000001 << len_eff) - 25'h0000001;
	assign ref_len_add = ({1'b0, a_operand} & len_mask) + ({1'b0, b_operand} & len_mask)
		+ {24'h000000, carry_flag_i};
	assign ref_dig_add = {1'b0, a_operand[3:0]} + {1'b0, b_operand[3:0]}
		+ {4'h0, carry_flag_i};
	assign ref_dig_sub = {1'b0, a_operand[3:0]} - {1'b0, b_operand[3:0]}
		- {4'h0, carry_flag_i};
	assign ref_bcd_add = (ref_dig_add > 5'h09) ? 4'(ref_dig_add - 5'h0a) : ref_dig_add[3:0];
	assign ref_bcd_sub = ref_dig_sub[4] ? 4'(ref_dig_sub + 5'h0a) : ref_dig_sub[3:0];
	assign digits_ok = (a_operand[3:0] <= adder_pkg::BCD_MAX)
		&& (b_operand[3:0] <= adder_pkg::BCD_MAX);

	// full binary add: result and carry match a plus b plus flag
	chk_binary_add_sum: assert property ( // see (RQ3) (RQ13)
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && !subtract_i && !bcd_mode && len_eff == adder_pkg::LEN_FULL
		|=> {carry_out_level_o, result_o} == $past(ref_add))
		else $error("binary sum or carry wrong");

	// full binary subtract: borrow out is the top bit of the wide difference
	chk_binary_sub_diff: assert property ( // see (RQ20) (RQ21)
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && subtract_i && !bcd_mode && len_eff == adder_pkg::LEN_FULL
		|=> result_o == $past(ref_sub[23:0]) && carry_out_level_o == $past(ref_sub[24]))
		else $error("binary difference or borrow wrong");

	// add propagate equals exclusive-or, whatever the carries do
	chk_add_propagate: assert property ( // see (RQ4)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i |-> prop_term == (a_operand ^ b_operand))
		else $error("add propagate not exclusive-or");

	// add generate equals and of the two bits
	chk_add_generate: assert property ( // see (RQ5)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i |-> gen_term == (a_operand & b_operand))
		else $error("add generate not and");

	// binary carry level is taken at the selected length
	chk_length_carry: assert property ( // see (RQ11)
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && !subtract_i && !bcd_mode
		|=> carry_out_level_o == $past(ref_len_add[len_eff]))
		else $error("carry level not at selected length");

	// a four-bit binary add leaves the next digit without the carry
	chk_carry_cut: assert property ( // see (RQ11)
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && !subtract_i && !bcd_mode && len_eff == adder_pkg::LEN_DIGIT
		|=> result_o[7:4] == $past(4'(a_operand[7:4] + b_operand[7:4])))
		else $error("carry leaked past selected stage");

	// single bcd digit sum is corrected and its decade carry shows as level
	chk_bcd_add_digit: assert property ( // see (RQ16) (RQ17) (RQ18)
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && !subtract_i && bcd_mode && digits_ok
		&& len_eff == adder_pkg::LEN_DIGIT
		|=> result_o[3:0] == $past(ref_bcd_add)
		&& carry_out_level_o == $past(ref_dig_add > 5'h09))
		else $error("bcd sum digit or decade carry wrong");

	// single bcd digit difference is corrected by minus six on a borrow
	chk_bcd_sub_digit: assert property ( // see (RQ22)
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && subtract_i && bcd_mode && digits_ok
		&& len_eff == adder_pkg::LEN_DIGIT
		|=> result_o[3:0] == $past(ref_bcd_sub)
		&& carry_out_level_o == $past(ref_dig_sub[4]))
		else $error("bcd difference digit or borrow wrong");

	// address and literal selects reach the operands unchanged
	chk_operand_select: assert property ( // see (RQ2)
		@(posedge clk_i) disable iff (rst_i)
		(a_sel_i == adder_pkg::A_SEL_ADDR && b_sel_i == adder_pkg::B_SEL_LITERAL)
		|-> a_operand == field_address_reg_i && b_operand == micro_literal_i)
		else $error("operand select wrong");

	// result and carry level hold between requests, valid low
	chk_result_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!op_valid_i |=> $stable(result_o) && $stable(carry_out_level_o) && !result_valid_o)
		else $error("result changed without request");

	// carry into weight 2 of the low digit, recovered from the sum as s ^ a ^ b
	chk_weight2_carry: assert property ( // see (RQ7)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i |-> all_carry[1] == (ref_dig_add[1] ^ a_operand[1] ^ b_operand[1]))
		else $error("carry into weight 2 wrong");

	// weight-4 carry, bcd mode leaves it untouched
	chk_weight4_carry: assert property ( // see (RQ8)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i |-> all_carry[2] == (ref_dig_add[2] ^ a_operand[2] ^ b_operand[2]))
		else $error("carry into weight 4 wrong");

	// weight-8 carry through the whole propagate chain
	chk_weight8_carry: assert property ( // see (RQ9)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i |-> all_carry[3] == (ref_dig_add[3] ^ a_operand[3] ^ b_operand[3]))
		else $error("carry into weight 8 wrong");

	// binary stage carry out equals the fifth bit of the digit sum
	chk_stage_carry_out: assert property ( // see (RQ10) (RQ6)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i && !bcd_mode
		|-> all_carry[4] == ref_dig_add[4])
		else $error("stage carry out wrong");

	// subtract turns the chain into borrows, stage borrow out included
	chk_borrow_chain: assert property ( // see (RQ20) (RQ21)
		@(posedge clk_i) disable iff (rst_i)
		subtract_i
		|-> all_carry[4:1] == {ref_dig_sub[4], ref_dig_sub[3:1] ^ a_operand[3:1] ^ b_operand[3:1]})
		else $error("borrow chain wrong");

	// decade carry forced at ten or more, whatever the binary carry does
	chk_decade_carry: assert property ( // see (RQ17) (RQ19)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i && bcd_mode && digits_ok
		|-> all_carry[4] == (ref_dig_add > 5'h09))
		else $error("decade carry wrong");

	// corrected low bcd sum digit, at any length
	chk_bcd_low_sum: assert property ( // see (RQ16)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i && bcd_mode && digits_ok
		|-> result_next[3:0] == ref_bcd_add)
		else $error("bcd low sum digit wrong");

	// corrected low bcd difference digit, at any length
	chk_bcd_low_diff: assert property ( // see (RQ22)
		@(posedge clk_i) disable iff (rst_i)
		subtract_i && bcd_mode && digits_ok
		|-> result_next[3:0] == ref_bcd_sub)
		else $error("bcd low difference digit wrong");

	// full width: carry reaches stage 3 through stages 0 to 2
	chk_stage_chain: assert property ( // see (RQ1)
		@(posedge clk_i) disable iff (rst_i)
		!subtract_i && !bcd_mode && len_eff == adder_pkg::LEN_FULL
		|-> all_carry[12] == (ref_add[12] ^ a_operand[12] ^ b_operand[12]))
		else $error("carry not chained between stages");

	// every mode code but bcd gives a plain binary sum
	chk_non_bcd_binary: assert property ( // see (RQ14)
		@(posedge clk_i) disable iff (rst_i)
		mode_i != adder_pkg::MODE_BCD && !subtract_i && len_eff == adder_pkg::LEN_FULL
		|-> result_next == ref_add[23:0])
		else $error("non-bcd mode not binary");

	// each request is marked one cycle later
	chk_valid_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i |=> result_valid_o)
		else $error("result valid missing after request");

endmodule

/* hw/adder_pkg.sv */
// constants shared by the 24-bit binary/bcd lookahead adder and its digit stage
// assumes: single clock domain, operands delivered by same-clock processor logic
package adder_pkg;

	// datapath geometry
	localparam int DATA_W = 24;
	localparam int DIGIT_W = 4;
	localparam int STAGES = 6;
	localparam int LEN_W = 5;
	localparam int MODE_W = 2;

	// longest operation in bits, also used for out-of-range lengths
	localparam logic [4:0] LEN_FULL = 5'h18;
	// single bcd digit length
	localparam logic [4:0] LEN_DIGIT = 5'h04;

	// arithmetic type field encodings
	localparam logic [1:0] MODE_BINARY = 2'h0;
	localparam logic [1:0] MODE_BCD = 2'h1;

	// bcd decade correction value
	localparam logic [3:0] SIX_CORR = 4'h6;
	// largest legal bcd digit
	localparam logic [3:0] BCD_MAX = 4'h9;

	// values after reset
	localparam logic [23:0] RESULT_RST = 24'h000000;
	localparam logic [5:0] DIGIT_CARRY_RST = 6'h00;
	localparam logic CARRY_RST = 1'b0;

	// a operand sources
	typedef enum logic [1:0] {
		A_SEL_FIRST = 2'h0,
		A_SEL_ADDR = 2'h1,
		A_SEL_LEN = 2'h2
	} a_sel_t;

	// b operand sources
	typedef enum logic [1:0] {
		B_SEL_SECOND = 2'h0,
		B_SEL_LITERAL = 2'h1,
		B_SEL_LENFLD = 2'h2,
		B_SEL_SCRATCH = 2'h3
	} b_sel_t;

endpackage

/* hw/lookahead_stage.sv */
// one modulo-sixteen digit stage: parallel carry lookahead, sum, bcd correction
// assumes: generate/propagate/half-sum terms are formed by the parent per bit
`timescale 1ns/1ps
module lookahead_stage (
	// per-bit terms
	input wire logic [3:0] half_i,
	input wire logic [3:0] gen_i,
	input wire logic [3:0] prop_i,
	// stage carry or borrow in
	input wire logic carry_i,
	// arithmetic type of this operation
	input wire logic bcd_add_i,
	input wire logic bcd_sub_i,
	// results
	output logic [3:0] digit_o,
	output logic [3:0] bit_carry_o
);

	logic c2; // carry into weight 2
	logic c4; // carry into weight 4
	logic c8; // carry into weight 8
	logic internal_stage_carry; // lookahead element carry from generates and propagates, no carry-in
	logic c16; // binary stage carry out
	logic c10; // decade carry for bcd sum
	logic [3:0] raw; // binary digit before any correction

	// all carries are flat sums of products, no ripple through bits
	always_comb begin // see (RQ6)
		c2 = gen_i[0] | (prop_i[0] & carry_i); // see (RQ7)
		c4 = gen_i[1] | (prop_i[1] & gen_i[0]) | (prop_i[1] & prop_i[0] & carry_i); // see (RQ8)
		c8 = gen_i[2] | (prop_i[2] & gen_i[1]) | (prop_i[2] & prop_i[1] & gen_i[0])
			| (prop_i[2] & prop_i[1] & prop_i[0] & carry_i); // see (RQ9)
		internal_stage_carry = gen_i[3] | (prop_i[3] & gen_i[2])
			| (prop_i[3] & prop_i[2] & gen_i[1])
			| (prop_i[3] & prop_i[2] & prop_i[1] & gen_i[0]); // see (RQ10)
		// carry-in term kept outside the internal carry, as a separate gate
		c16 = internal_stage_carry | (&prop_i & carry_i); // see (RQ10)
	end

	// sum bit is half-sum xor incoming carry, add and subtract alike
	assign raw = half_i ^ {c8, c4, c2, carry_i}; // see (RQ3)

	// decade carry: binary carry, or a result of ten or more
	assign c10 = c16 | (raw[3] & raw[1]) | (raw[3] & raw[2]); // see (RQ17)

	// digit correction; carry comes from the adder path, never the +6 box
	always_comb begin
		if (bcd_add_i && c10) begin
			digit_o = raw + adder_pkg::SIX_CORR; // see (RQ16)
		end else if (bcd_sub_i && c16) begin
			digit_o = raw - adder_pkg::SIX_CORR; // see (RQ22)
		end else begin
			digit_o = raw;
		end
	end

	// borrow is not decade-adjusted in subtraction
	assign bit_carry_o = {(bcd_add_i ? c10 : c16), c8, c4, c2}; // see (RQ19)

endmodule

/* sim/binary_bcd_lookahead_adder_tb.sv */
// self-checking bench for the 24-bit binary/bcd lookahead adder
// assumes: design files from hw/ compiled first, assertions live inside them
`timescale 1ns/1ps
module binary_bcd_lookahead_adder_tb;
	// clock, reset and request
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic op_valid_i = 1'b0;
	logic subtract_i = 1'b0;
	logic [1:0] mode_i = 2'h0;
	logic [4:0] operand_length_field_i = 5'h18;
	logic carry_flag_i = 1'b0;
	// operand sources
	logic [1:0] a_sel_i = 2'h0;
	logic [23:0] first_operand_i = 24'h000000;
	logic [23:0] field_address_reg_i = 24'h000200;
	logic [23:0] field_length_reg_i = 24'h003000;
	logic [1:0] b_sel_i = 2'h0;
	logic [23:0] second_operand_i = 24'h000000;
	logic [23:0] micro_literal_i = 24'h000020;
	logic [23:0] left_scratchpad_i = 24'h000400;
	// results
	logic [23:0] result_o;
	logic carry_out_level_o;
	logic [5:0] digit_carry_o;
	logic result_valid_o;
	// bookkeeping
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;

	bcd_lookahead_adder bcd_lookahead_adder_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.op_valid_i(op_valid_i),
		.subtract_i(subtract_i),
		.mode_i(mode_i),
		.operand_length_field_i(operand_length_field_i),
		.carry_flag_i(carry_flag_i),
		.a_sel_i(a_sel_i),
		.first_operand_i(first_operand_i),
		.field_address_reg_i(field_address_reg_i),
		.field_length_reg_i(field_length_reg_i),
		.b_sel_i(b_sel_i),
		.second_operand_i(second_operand_i),
		.micro_literal_i(micro_literal_i),
		.left_scratchpad_i(left_scratchpad_i),
		.result_o(result_o),
		.carry_out_level_o(carry_out_level_o),
		.digit_carry_o(digit_carry_o),
		.result_valid_o(result_valid_o)
	);

	// 200 mhz clock
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// hang guard, far above the under a hundred cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// one comparison, four-state exact
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// summary then verdict
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one request, result judged one cycle later while valid stands
	task automatic run_op(input logic s, input logic [1:0] m, input logic [4:0] len,
		input logic cf, input logic [1:0] as, input logic [1:0] bs,
		input logic [23:0] a, input logic [23:0] b, input logic [23:0] er, input logic el);
		@(negedge clk_i);
		subtract_i = s;
		mode_i = m;
		operand_length_field_i = len;
		carry_flag_i = cf;
		a_sel_i = as;
		b_sel_i = bs;
		first_operand_i = a;
		second_operand_i = b;
		op_valid_i = 1'b1;
		@(negedge clk_i);
		op_valid_i = 1'b0;
		check(result_o, er);
		check({23'h0, carry_out_level_o}, {23'h0, el});
		check({23'h0, result_valid_o}, 24'h000001);
	endtask

	// outputs cleared while reset is held, and again on a mid-run reset
	task automatic t_reset();
		check(result_o, 24'h000000);
		check({23'h0, carry_out_level_o}, 24'h000000);
		check({18'h0, digit_carry_o}, 24'h0);
		check({23'h0, result_valid_o}, 24'h000000);
		rst_i = 1'b0;
		run_op(1'b0, 2'h0, 5'h18, 1'b0, 2'h0, 2'h0, 24'h000003, 24'h000004, 24'h000007, 1'b0);
		@(negedge clk_i);
		rst_i = 1'b1;
		#1;
		// asynchronous clear, no edge needed
		check(result_o, 24'h000000);
		check({23'h0, result_valid_o}, 24'h0);
		@(negedge clk_i);
		rst_i = 1'b0;
		// first edge after release, no request: still cleared
		@(negedge clk_i);
		check(result_o, 24'h000000);
		check({23'h0, result_valid_o}, 24'h0);
	endtask

	// binary sums, carry flag, carry chain patterns and length cut
	task automatic t_binary_add();
		run_op(1'b0, 2'h0, 5'h18, 1'b1, 2'h0, 2'h0, 24'hffffff, 24'h0, 24'h0, 1'b1);
		run_op(1'b0, 2'h0, 5'h00, 1'b0, 2'h0, 2'h0, 24'h800000, 24'h800000, 24'h0, 1'b1);
		// software feeds the level back as the next carry flag
		run_op(1'b0, 2'h0, 5'h18, carry_out_level_o, 2'h0, 2'h0, 24'h1, 24'h2, 24'h4, 1'b0);
		run_op(1'b0, 2'h0, 5'h18, 1'b0, 2'h0, 2'h0, 24'h123456, 24'h654321,
			24'h777777, 1'b0);
		run_op(1'b0, 2'h0, 5'h04, 1'b0, 2'h0, 2'h0, 24'h8, 24'h9, 24'h1, 1'b1);
		run_op(1'b0, 2'h0, 5'h04, 1'b0, 2'h0, 2'h0, 24'h1, 24'h1, 24'h2, 1'b0);
		run_op(1'b0, 2'h0, 5'h04, 1'b0, 2'h0, 2'h0, 24'hc, 24'h4, 24'h0, 1'b1);
		run_op(1'b0, 2'h0, 5'h04, 1'b0, 2'h0, 2'h0, 24'h6, 24'ha, 24'h0, 1'b1);
		run_op(1'b0, 2'h0, 5'h04, 1'b0, 2'h0, 2'h0, 24'h5, 24'hb, 24'h0, 1'b1);
		run_op(1'b0, 2'h0, 5'h04, 1'b1, 2'h0, 2'h0, 24'ha, 24'h5, 24'h0, 1'b1);
		// carry ripples through an all-propagate stage, then is cut at bit 8
		run_op(1'b0, 2'h0, 5'h08, 1'b0, 2'h0, 2'h0, 24'hf8, 24'h9, 24'h1, 1'b1);
		// stages 0 and 1 carry out, stage 2 gets nothing
		check({18'h0, digit_carry_o}, 24'h000003);
		// mode 2 runs binary
		run_op(1'b0, 2'h2, 5'h18, 1'b0, 2'h0, 2'h0, 24'h9, 24'h1, 24'ha, 1'b0);
	endtask

	// binary and bcd differences with borrow
	task automatic t_subtract();
		run_op(1'b1, 2'h0, 5'h18, 1'b1, 2'h0, 2'h0, 24'h5, 24'h3, 24'h1, 1'b0);
		run_op(1'b1, 2'h0, 5'h18, 1'b0, 2'h0, 2'h0, 24'h3, 24'h5, 24'hfffffe, 1'b1);
		run_op(1'b1, 2'h1, 5'h08, 1'b0, 2'h0, 2'h0, 24'h17, 24'h9, 24'h8, 1'b0);
		run_op(1'b1, 2'h1, 5'h08, 1'b0, 2'h0, 2'h0, 24'h0, 24'h1, 24'h99, 1'b1);
		run_op(1'b1, 2'h1, 5'h04, 1'b0, 2'h0, 2'h0, 24'h9, 24'h7, 24'h2, 1'b0);
	endtask

	// bcd sums: six-correction, forced decade carry, multi-digit chain
	task automatic t_bcd_add();
		run_op(1'b0, 2'h1, 5'h04, 1'b0, 2'h0, 2'h0, 24'h7, 24'h8, 24'h5, 1'b1);
		run_op(1'b0, 2'h1, 5'h04, 1'b0, 2'h0, 2'h0, 24'h7, 24'h3, 24'h0, 1'b1);
		run_op(1'b0, 2'h1, 5'h04, 1'b0, 2'h0, 2'h0, 24'h7, 24'h1, 24'h8, 1'b0);
		run_op(1'b0, 2'h1, 5'h18, 1'b0, 2'h0, 2'h0, 24'h999999, 24'h1, 24'h0, 1'b1);
		// every digit forces its decade carry
		check({18'h0, digit_carry_o}, 24'h00003f);
		run_op(1'b0, 2'h1, 5'h08, 1'b1, 2'h0, 2'h0, 24'h45, 24'h55, 24'h1, 1'b1);
	endtask

	// every a and b source pairing, values chosen so sums are unique
	task automatic t_sources();
		logic [23:0] a_tab [3];
		logic [23:0] b_tab [4];
		a_tab = '{24'h000010, 24'h000200, 24'h003000};
		b_tab = '{24'h000001, 24'h000020, 24'h000018, 24'h000400};
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 4; j++) begin
				run_op(1'b0, 2'h0, 5'h18, 1'b0, 2'(i), 2'(j), 24'h000010, 24'h000001,
					a_tab[i] + b_tab[j], 1'b0);
			end
		end
	endtask

	// back-to-back requests, then results hold with no request
	task automatic t_back_to_back();
		@(negedge clk_i);
		subtract_i = 1'b0;
		mode_i = 2'h0;
		a_sel_i = 2'h0;
		b_sel_i = 2'h0;
		carry_flag_i = 1'b0;
		first_operand_i = 24'h000100;
		second_operand_i = 24'h000023;
		op_valid_i = 1'b1;
		@(negedge clk_i);
		check(result_o, 24'h000123);
		subtract_i = 1'b1;
		@(negedge clk_i);
		op_valid_i = 1'b0;
		check(result_o, 24'h0000dd);
		check({23'h0, result_valid_o}, 24'h000001);
		@(negedge clk_i);
		// valid is a pulse, data stays
		check({23'h0, result_valid_o}, 24'h000000);
		check(result_o, 24'h0000dd);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		t_reset();
		t_binary_add();
		t_subtract();
		t_bcd_add();
		t_sources();
		t_back_to_back();
		print_verdict();
	end
endmodule
